// ---- core/pod_classify.sv ----
// Purpose: Classify one opcode under its prefix into group and operands.
// Assumes: Prefix already separated from the opcode by the caller.
// Notes: Unused encodings fall into the none group and report illegal.
`timescale 1ns/1ns
module pod_classify (
    pod_cls_if.cls c
);
    wire [3:0] col = c.opcode[7:4];
    wire [3:0] lo = c.opcode[3:0];
    wire col_rmw = (col >= pod_pkg::COL_RMW_DIR) &&
                   (col <= pod_pkg::COL_RMW_IDX0);
    wire col_alu = col >= pod_pkg::COL_IMM;
    wire x_indexed = (col == pod_pkg::COL_RMW_IDX1) ||
                     (col == pod_pkg::COL_IDX2) ||
                     (col == pod_pkg::COL_IDX1);
    wire idx_any = x_indexed || (col == pod_pkg::COL_RMW_IDX0) ||
                   (col == pod_pkg::COL_IDX0);
    wire x_reg = (col == pod_pkg::COL_RMW_X) ||
                 (col_alu && (lo == 4'h3 || lo == 4'hE || lo == 4'hF)) ||
                 (c.opcode == 8'h42) || (c.opcode == 8'h85) ||
                 (c.opcode == 8'h89) ||
                 (c.opcode >= 8'h93 && c.opcode <= 8'h97);
    // X-based covers indexed, inherent-on-X and X-destination forms.
    wire x_based = idx_any || x_reg;
    wire direct_based = (col == pod_pkg::COL_BIT_BRANCH) ||
                        (col == pod_pkg::COL_BIT_OP) ||
                        (col == pod_pkg::COL_RMW_DIR) ||
                        (col == pod_pkg::COL_DIR) ||
                        (col == pod_pkg::COL_EXT);
    wire ok_y = x_based; // [RULE5] [RULE6]
    wire ok_ind = direct_based || x_indexed; // [RULE5] [RULE7] [RULE8]
    wire ok_yind = x_indexed; // [RULE5] [RULE9]
    wire pfx_ok = (c.pfx == pod_pkg::PFX_NONE) ||
                  (c.pfx == pod_pkg::PFX_Y && ok_y) ||
                  (c.pfx == pod_pkg::PFX_IND && ok_ind) ||
                  (c.pfx == pod_pkg::PFX_YIND && ok_yind);
    wire is_ind = (c.pfx == pod_pkg::PFX_IND) ||
                  (c.pfx == pod_pkg::PFX_YIND);
    logic [1:0] base_ops;
    pod_pkg::pod_grp_e grp_w;

    // Base operand count per addressing column.
    always_comb begin
        case (col)
            pod_pkg::COL_BIT_BRANCH, pod_pkg::COL_EXT,
            pod_pkg::COL_IDX2: base_ops = 2'h2;
            pod_pkg::COL_BIT_OP, pod_pkg::COL_REL, pod_pkg::COL_RMW_DIR,
            pod_pkg::COL_RMW_IDX1, pod_pkg::COL_IMM, pod_pkg::COL_DIR,
            pod_pkg::COL_IDX1: base_ops = 2'h1;
            default: base_ops = 2'h0;
        endcase
    end

    // Group per opcode; 13 groups span the base instruction set. [RULE1]
    always_comb begin
        grp_w = pod_pkg::GRP_NONE;
        if (col == pod_pkg::COL_BIT_BRANCH) begin
            grp_w = pod_pkg::GRP_BITBR;
        end else if (col == pod_pkg::COL_BIT_OP) begin
            grp_w = pod_pkg::GRP_BIT;
        end else if (col == pod_pkg::COL_REL) begin
            grp_w = (lo == 4'h0) ? pod_pkg::GRP_JUMP : pod_pkg::GRP_COND;
        end else if (col_rmw) begin
            case (lo)
                4'h0, 4'h3: grp_w = pod_pkg::GRP_LOGIC;
                4'h2: grp_w = (c.opcode == 8'h42) ? pod_pkg::GRP_ARITH
                                                  : pod_pkg::GRP_NONE;
                4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE: grp_w = pod_pkg::GRP_SHIFT;
                4'hA, 4'hC: grp_w = pod_pkg::GRP_INCDEC;
                4'hD: grp_w = pod_pkg::GRP_CMP;
                4'hF: grp_w = pod_pkg::GRP_LOAD;
                default: grp_w = pod_pkg::GRP_NONE;
            endcase
        end else if (col_alu) begin
            case (lo)
                4'h0, 4'h2, 4'h9, 4'hB: grp_w = pod_pkg::GRP_ARITH;
                4'h1, 4'h3, 4'h5: grp_w = pod_pkg::GRP_CMP;
                4'h4, 4'h8, 4'hA: grp_w = pod_pkg::GRP_LOGIC;
                4'hC, 4'hD: grp_w = pod_pkg::GRP_JUMP;
                default: grp_w = pod_pkg::GRP_LOAD;
            endcase
            if (col == pod_pkg::COL_IMM && (lo == 4'h7 || lo == 4'hC ||
                                            lo == 4'hF)) begin
                grp_w = (lo == 4'hD) ? grp_w : pod_pkg::GRP_NONE;
            end
            if (col == pod_pkg::COL_IMM && lo == 4'hD) begin
                grp_w = pod_pkg::GRP_JUMP;
            end
        end else begin
            case (c.opcode)
                8'h80, 8'h83, 8'h8E, 8'h8F: grp_w = pod_pkg::GRP_INT;
                8'h81, 8'h9D: grp_w = pod_pkg::GRP_JUMP;
                8'h84, 8'h85, 8'h86, 8'h88, 8'h89, 8'h8A, 8'h9C:
                    grp_w = pod_pkg::GRP_STACK;
                8'h93, 8'h94, 8'h95, 8'h96, 8'h97: grp_w = pod_pkg::GRP_LOAD;
                8'h98, 8'h99, 8'h9A, 8'h9B: grp_w = pod_pkg::GRP_FLAG;
                default: grp_w = pod_pkg::GRP_NONE;
            endcase
        end
    end

    assign c.grp = grp_w;
    assign c.legal = pfx_ok && (grp_w != pod_pkg::GRP_NONE);
    // Indirect forms carry a one-byte pointer, plus the branch offset.
    assign c.ops = !is_ind ? base_ops :
                   (col == pod_pkg::COL_BIT_BRANCH) ? 2'h2 : 2'h1; // [RULE4]
    assign c.idx_y = (c.pfx == pod_pkg::PFX_Y) ||
                     (c.pfx == pod_pkg::PFX_YIND); // [RULE6] [RULE9]
    assign c.indirect = is_ind; // [RULE7] [RULE8]
endmodule

// ---- core/pod_cls_if.sv ----
// Purpose: Carries one opcode and its prefix to the classifier and back.
// Assumes: Purely combinational traffic within one clock.
// Notes: The decoder owns the request side.
`timescale 1ns/1ns
interface pod_cls_if;
    logic [7:0] opcode;
    pod_pkg::pod_pfx_e pfx;
    pod_pkg::pod_grp_e grp;
    logic [1:0] ops;
    logic idx_y;
    logic indirect;
    logic legal;
    modport dec (output opcode, output pfx, input grp, input ops,
                 input idx_y, input indirect, input legal);
    modport cls (input opcode, input pfx, output grp, output ops,
                 output idx_y, output indirect, output legal);
endinterface

// ---- core/pod_decoder.sv ----
// Purpose: Split the fetched byte stream into prefixed instructions.
// Assumes: Bytes come from same-clock fetch logic, one per valid cycle.
// Notes: Results stand from one report until the next opcode byte is taken.
`timescale 1ns/1ns
module pod_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    output logic insn_valid_o,
    output logic [7:0] opcode_o,
    output logic [1:0] prefix_o,
    output logic index_y_o,
    output logic indirect_o,
    output logic [3:0] group_o,
    output logic [1:0] operand_count_o,
    output logic [2:0] length_o,
    output logic [15:0] operand_o,
    output logic illegal_o,
    output logic pending_o
);
    pod_cls_if cif ();
    pod_classify u_cls (.c(cif.cls));

    pod_pkg::pod_state_e state_r;
    pod_pkg::pod_pfx_e pfx_r;
    logic pfx_dup_r;
    logic insn_valid_r;
    logic [7:0] opcode_r;
    pod_pkg::pod_pfx_e pfx_out_r;
    logic idx_y_r;
    logic ind_r;
    pod_pkg::pod_grp_e grp_r;
    logic [1:0] ops_r;
    logic [1:0] left_r;
    logic [2:0] length_r;
    logic [15:0] operand_r;
    logic illegal_r;

    wire take = ce_i && byte_valid_i;
    wire in_opc = (state_r == pod_pkg::ST_OPCODE);
    wire is_pfx_y = byte_i == pod_pkg::Y_SUBSTITUTE_PREFIX;
    wire is_pfx_i = byte_i == pod_pkg::INDIRECT_MODE_PREFIX;
    wire is_pfx_yi = byte_i == pod_pkg::Y_INDIRECT_INDEXED_PREFIX;
    wire is_pfx = is_pfx_y || is_pfx_i || is_pfx_yi; // [RULE3]
    wire take_pfx = take && in_opc && is_pfx;
    wire take_opc = take && in_opc && !is_pfx;
    wire take_opr = take && !in_opc;
    wire last_opr = take_opr && (left_r == 2'h1);
    wire has_pfx = pfx_r != pod_pkg::PFX_NONE;
    wire [2:0] len_w = 3'h1 + {2'h0, has_pfx} + {1'b0, cif.ops}; // [RULE2]
    wire emit_now = take_opc && (cif.ops == 2'h0);
    pod_pkg::pod_pfx_e pfx_new;

    assign pfx_new = is_pfx_y ? pod_pkg::PFX_Y :
                     is_pfx_i ? pod_pkg::PFX_IND : pod_pkg::PFX_YIND;
    assign cif.opcode = byte_i;
    assign cif.pfx = pfx_r;

    // Sequencer: opcode stage waits for operands when the mode needs them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= pod_pkg::ST_OPCODE;
        end else if (take_opc && cif.ops != 2'h0) begin
            state_r <= pod_pkg::ST_OPERAND; // [RULE4]
        end else if (last_opr) begin
            state_r <= pod_pkg::ST_OPCODE;
        end
    end

    // A prefix only arms the next opcode and is consumed by it. [RULE10]
    // A repeated prefix replaces the first and flags the result illegal.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pfx_r <= pod_pkg::PFX_NONE;
            pfx_dup_r <= 1'b0;
        end else if (take_pfx) begin
            pfx_r <= pfx_new; // [RULE3] [RULE4]
            pfx_dup_r <= has_pfx;
        end else if (take_opc) begin
            pfx_r <= pod_pkg::PFX_NONE;
            pfx_dup_r <= 1'b0;
        end
    end

    // Opcode results are latched when the opcode byte is taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opcode_r <= pod_pkg::RST_OPCODE;
            pfx_out_r <= pod_pkg::PFX_NONE;
            idx_y_r <= 1'b0;
            ind_r <= 1'b0;
            grp_r <= pod_pkg::GRP_NONE;
            ops_r <= 2'h0;
            length_r <= pod_pkg::RST_LENGTH;
            illegal_r <= 1'b0;
        end else if (take_opc) begin
            opcode_r <= byte_i;
            pfx_out_r <= pfx_r;
            idx_y_r <= cif.idx_y; // [RULE6] [RULE9]
            ind_r <= cif.indirect; // [RULE7] [RULE8]
            grp_r <= cif.grp; // [RULE1]
            ops_r <= cif.ops;
            length_r <= len_w; // [RULE2]
            illegal_r <= !cif.legal || pfx_dup_r; // [RULE5]
        end
    end

    // Operand bytes arrive low address first and shift in high first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            operand_r <= pod_pkg::RST_OPERAND;
            left_r <= 2'h0;
        end else if (take_opc) begin
            operand_r <= pod_pkg::RST_OPERAND;
            left_r <= cif.ops;
        end else if (take_opr) begin
            operand_r <= {operand_r[7:0], byte_i};
            left_r <= left_r - 2'h1;
        end
    end

    // Report pulse lasts one enabled cycle; a low enable freezes it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            insn_valid_r <= 1'b0;
        end else if (ce_i) begin
            insn_valid_r <= emit_now || last_opr; // [RULE10]
        end
    end

    assign insn_valid_o = insn_valid_r;
    assign opcode_o = opcode_r;
    assign prefix_o = pfx_out_r;
    assign index_y_o = idx_y_r;
    assign indirect_o = ind_r;
    assign group_o = grp_r;
    assign operand_count_o = ops_r;
    assign length_o = length_r;
    assign operand_o = operand_r;
    assign illegal_o = illegal_r;
    assign pending_o = state_r == pod_pkg::ST_OPERAND;

    // All checks below live in the core clock domain and sleep in reset.
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_prefix_taken;
        take_pfx && !has_pfx;
    endsequence
    sequence s_bare_opcode;
        take_opc && !has_pfx && cif.ops == 2'h0;
    endsequence
    sequence s_opcode_waits;
        take_opc && cif.ops != 2'h0;
    endsequence
    sequence s_second_prefix;
        take_pfx && has_pfx;
    endsequence

    a_length_range: assert property ( // [RULE2]
        insn_valid_o |-> (length_o >= 3'h1 && length_o <= 3'h4))
        else $error("Instruction length outside one to four.");
    a_length_sum: assert property ( // [RULE4]
        insn_valid_o |-> length_o == 3'h1 + {2'h0, prefix_o != 2'h0}
                                    + {1'b0, operand_count_o})
        else $error("Length does not match prefix and operands.");
    a_prefix_silent: assert property ( // [RULE10]
        s_prefix_taken |=> !insn_valid_o && !pending_o)
        else $error("A prefix byte produced an instruction.");
    a_bare_base: assert property ( // [RULE10]
        s_bare_opcode |=> insn_valid_o && prefix_o == 2'h0 &&
                          !index_y_o && !indirect_o)
        else $error("Bare opcode did not decode at once in base form.");
    a_y_swap: assert property ( // [RULE6]
        insn_valid_o && prefix_o == 2'(pod_pkg::PFX_Y)
            |-> index_y_o && !indirect_o)
        else $error("Y prefix did not select the Y register.");
    a_ind_form: assert property ( // [RULE7]
        insn_valid_o && prefix_o == 2'(pod_pkg::PFX_IND)
            |-> indirect_o && !index_y_o && operand_count_o != 2'h0)
        else $error("Indirect prefix did not give an indirect form.");
    a_yind_form: assert property ( // [RULE9]
        insn_valid_o && prefix_o == 2'(pod_pkg::PFX_YIND)
            |-> indirect_o && index_y_o)
        else $error("Indirect Y prefix did not give the Y form.");
    a_ind_indexed: assert property ( // [RULE8]
        insn_valid_o && !illegal_o && prefix_o == 2'(pod_pkg::PFX_IND) &&
        opcode_o[7:4] == pod_pkg::COL_IDX1 |-> operand_count_o == 2'h1)
        else $error("Indirect indexed form has the wrong operand count.");
    a_group_known: assert property ( // [RULE1]
        insn_valid_o && !illegal_o |-> group_o < 4'(pod_pkg::NUM_GROUPS))
        else $error("Legal instruction without a group.");
    a_prefix_scope: assert property ( // [RULE5]
        insn_valid_o && prefix_o == 2'(pod_pkg::PFX_YIND) &&
        opcode_o[7:4] == pod_pkg::COL_DIR |-> illegal_o)
        else $error("Prefix accepted on an opcode it cannot modify.");
    a_two_operands: assert property ( // [RULE4]
        take_opc && cif.ops == 2'h2 && ce_i ##1 take_opr ##1 take_opr
            |=> insn_valid_o)
        else $error("Two operand bytes did not complete the instruction.");
    a_operand_wait: assert property ( // [RULE4]
        s_opcode_waits |=> pending_o && !insn_valid_o)
        else $error("Opcode with operands did not wait for them.");
    a_double_prefix: assert property ( // [RULE10]
        s_second_prefix |=> !insn_valid_o && !pending_o)
        else $error("A repeated prefix produced an instruction.");
    a_dup_illegal: assert property ( // [RULE10]
        take_opc && pfx_dup_r |=> illegal_o)
        else $error("Opcode after two prefixes was not flagged.");
    // A report that meets a low enable must survive until it is taken.
    a_enable_hold: assert property ( // [RULE10]
        !ce_i && insn_valid_o |=> insn_valid_o)
        else $error("Report lost while the enable was low.");
    a_enable_freeze: assert property ( // [RULE4]
        !ce_i |=> $stable(pending_o) && $stable(operand_o))
        else $error("State moved while the enable was low.");
endmodule

// ---- core/pod_pkg.sv ----
// Purpose: Shared constants and types of the prefixed opcode decoder.
// Assumes: One opcode byte per accepted cycle from the fetch path.
// Notes: Opcode columns follow the high nibble of the opcode byte.
// Notes on behaviour
// (RULE1) Recognise 63 instructions in 13 groups.
// (RULE2) Instruction length is one to four bytes.
// (RULE3) One opcode byte; three prefix values extend it.
// (RULE4) Prefix precedes opcode; zero to two operands follow.
// (RULE5) Prefixes modify only X-based or direct opcodes.
// (RULE6) Prefix 90 swaps X for Y.
// (RULE7) Prefix 92 makes direct forms indirect.
// (RULE8) Prefix 92 makes X-indexed indirect X-indexed.
// (RULE9) Prefix 91 makes X indirect indexed use Y.
// (RULE10) Bare opcode is base; prefix never executes alone.
package pod_pkg;
    localparam logic [7:0] Y_SUBSTITUTE_PREFIX = 8'h90;
    localparam logic [7:0] Y_INDIRECT_INDEXED_PREFIX = 8'h91;
    localparam logic [7:0] INDIRECT_MODE_PREFIX = 8'h92;
    localparam int NUM_GROUPS = 13;
    localparam int NUM_INSNS = 63;
    localparam int MAX_OPERANDS = 2;
    localparam logic [7:0] RST_OPCODE = 8'h00;
    localparam logic [15:0] RST_OPERAND = 16'h0000;
    localparam logic [2:0] RST_LENGTH = 3'h1;
    // Addressing columns, taken from the opcode high nibble.
    localparam logic [3:0] COL_BIT_BRANCH = 4'h0;
    localparam logic [3:0] COL_BIT_OP = 4'h1;
    localparam logic [3:0] COL_REL = 4'h2;
    localparam logic [3:0] COL_RMW_DIR = 4'h3;
    localparam logic [3:0] COL_RMW_A = 4'h4;
    localparam logic [3:0] COL_RMW_X = 4'h5;
    localparam logic [3:0] COL_RMW_IDX1 = 4'h6;
    localparam logic [3:0] COL_RMW_IDX0 = 4'h7;
    localparam logic [3:0] COL_MISC0 = 4'h8;
    localparam logic [3:0] COL_MISC1 = 4'h9;
    localparam logic [3:0] COL_IMM = 4'hA;
    localparam logic [3:0] COL_DIR = 4'hB;
    localparam logic [3:0] COL_EXT = 4'hC;
    localparam logic [3:0] COL_IDX2 = 4'hD;
    localparam logic [3:0] COL_IDX1 = 4'hE;
    localparam logic [3:0] COL_IDX0 = 4'hF;
    typedef enum logic [1:0] {
        PFX_NONE, PFX_Y, PFX_IND, PFX_YIND
    } pod_pfx_e;
    typedef enum logic [3:0] {
        GRP_LOAD, GRP_STACK, GRP_INCDEC, GRP_CMP, GRP_LOGIC, GRP_BIT,
        GRP_BITBR, GRP_ARITH, GRP_SHIFT, GRP_JUMP, GRP_COND, GRP_INT,
        GRP_FLAG, GRP_NONE
    } pod_grp_e;
    typedef enum logic {
        ST_OPCODE, ST_OPERAND
    } pod_state_e;
endpackage

// ---- sim/pod_fetch_model.sv ----
// Purpose: Fetch-side partner that streams queued bytes into the decoder.
// Assumes: One byte is offered per cycle and held until ce_i takes it.
// Notes: Between bytes the data lines toggle so that stale bytes never
// pass for real ones; stall_i inserts gaps in the stream.
`timescale 1ns/1ns
module pod_fetch_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic stall_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o
);
    logic [7:0] fifo_q[$];

    task automatic push(input logic [7:0] b);
        fifo_q.push_back(b);
    endtask

    // A byte offered while ce_i is low is not yet taken, so it stays put.
    always @(posedge clk_i) begin
        if (rst_i) begin
            byte_valid_o <= 1'b0;
            byte_o <= 8'h5A;
        end else if (!(byte_valid_o && !ce_i)) begin
            if (fifo_q.size() != 0 && !stall_i) begin
                byte_o <= fifo_q.pop_front();
                byte_valid_o <= 1'b1;
            end else begin
                byte_valid_o <= 1'b0;
                byte_o <= ~byte_o;
            end
        end
    end
endmodule

// ---- sim/test_prebyte_opcode_decoder.sv ----
// Purpose: Self-checking bench of the prefixed opcode decoder.
// Assumes: Results are compared in order by a monitor against a queue.
// Notes: Operand bytes, clock enable and fetch gaps come from an LFSR.
`timescale 1ns/1ns
module test_prebyte_opcode_decoder;
    typedef struct packed {
        logic full; logic [7:0] opc; logic [1:0] pfx; logic iy; logic ind;
        logic [1:0] cnt; logic [2:0] len; logic [15:0] opd; logic ill;
        logic [3:0] grp;
    } pod_exp_s;
    logic clk_i, rst_i, ce_i, stall, rand_on, byte_valid, insn_valid_o;
    logic [7:0] byte_b, opcode_o;
    logic [1:0] prefix_o, operand_count_o;
    logic index_y_o, indirect_o, illegal_o, pending_o;
    logic [3:0] group_o;
    logic [2:0] length_o;
    logic [15:0] operand_o, lfsr_r;
    int errors, comparisons;
    pod_exp_s exp_q[$];

    pod_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .byte_valid_i(byte_valid), .byte_i(byte_b),
        .insn_valid_o(insn_valid_o), .opcode_o(opcode_o),
        .prefix_o(prefix_o), .index_y_o(index_y_o), .indirect_o(indirect_o),
        .group_o(group_o), .operand_count_o(operand_count_o),
        .length_o(length_o), .operand_o(operand_o), .illegal_o(illegal_o),
        .pending_o(pending_o));
    pod_fetch_model fetch_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .stall_i(stall), .byte_valid_o(byte_valid), .byte_o(byte_b));

    always #50 clk_i = ~clk_i;

    function automatic logic [15:0] pod_lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    always @(posedge clk_i) begin
        lfsr_r <= pod_lfsr(lfsr_r);
        ce_i <= rand_on ? (lfsr_r[2:0] != 3'h0) : 1'b1;
        stall <= rand_on ? (lfsr_r[5] & lfsr_r[9]) : 1'b0;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    // Pulses are taken only in enabled cycles, as ce_i low freezes them.
    always @(posedge clk_i) begin
        pod_exp_s e;
        if (!rst_i && ce_i && insn_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(16'h0001, 16'h0000);
            end else begin
                e = exp_q.pop_front();
                check(opcode_o, e.opc);
                check(illegal_o, e.ill);
                if (e.full) begin
                    check(prefix_o, e.pfx);
                    check(index_y_o, e.iy);
                    check(indirect_o, e.ind);
                    check(operand_count_o, e.cnt);
                    check(length_o, e.len);
                    check(operand_o, e.opd);
                    if (e.grp != 4'hF) check(group_o, e.grp);
                end
            end
        end
    end

    // Code 0 of pf means no prefix; pc is the prefix code expected.
    task automatic issue(input logic [7:0] pf, input logic [7:0] op,
                         input logic [1:0] n, input logic [1:0] pc,
                         input logic iy, input logic ind, input logic ill,
                         input logic full, input logic [3:0] grp);
        pod_exp_s e;
        logic [15:0] d;
        d = lfsr_r ^ {op, pf};
        if (n == 2'h1) d[15:8] = 8'h00;
        if (n == 2'h0) d = 16'h0000;
        if (pf != 8'h00) fetch_u.push(pf);
        fetch_u.push(op);
        if (n == 2'h2) fetch_u.push(d[15:8]);
        if (n != 2'h0) fetch_u.push(d[7:0]);
        e = '{full, op, pc, iy, ind, n, 3'(1 + (pf != 8'h00) + n), d, ill,
              grp};
        exp_q.push_back(e);
    endtask

    task automatic run_set;
        issue(8'h00, 8'h9D, 2'h0, 2'h0, 0, 0, 0, 1, 4'h9);
        issue(8'h00, 8'hC6, 2'h2, 2'h0, 0, 0, 0, 1, 4'h0);
        issue(8'h92, 8'hBB, 2'h1, 2'h2, 0, 1, 0, 1, 4'h7);
        issue(8'h92, 8'h00, 2'h2, 2'h2, 0, 1, 0, 1, 4'h6);
        issue(8'h92, 8'h3C, 2'h1, 2'h2, 0, 1, 0, 1, 4'h2);
        issue(8'h92, 8'hE6, 2'h1, 2'h2, 0, 1, 0, 1, 4'h0);
        issue(8'h91, 8'hD6, 2'h1, 2'h3, 1, 1, 0, 1, 4'h0);
        issue(8'h91, 8'hB6, 2'h1, 2'h3, 1, 1, 1, 1, 4'hF);
        issue(8'h90, 8'hF6, 2'h0, 2'h1, 1, 0, 0, 1, 4'h0);
        issue(8'h90, 8'hE6, 2'h1, 2'h1, 1, 0, 0, 1, 4'h0);
        issue(8'h90, 8'h9D, 2'h0, 2'h1, 0, 0, 1, 0, 4'hF);
        fetch_u.push(8'h90);
        issue(8'h92, 8'hBB, 2'h1, 2'h2, 0, 1, 1, 0, 4'hF);
        issue(8'h00, 8'h9D, 2'h0, 2'h0, 0, 0, 0, 1, 4'h9);
    endtask

    task automatic drain;
        for (int i = 0; i < 3000; i++) begin
            if (exp_q.size() == 0 && fetch_u.fifo_q.size() == 0) break;
            @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
        check(16'(exp_q.size()), 16'h0000);
        check(pending_o, 1'b0);
    endtask

    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({insn_valid_o, pending_o, illegal_o, index_y_o}, 16'h0000);
        check({opcode_o, prefix_o, indirect_o}, 16'h0000);
        check({group_o, operand_count_o, length_o}, 16'h01A1);
        check(operand_o, 16'h0000);
    endtask

    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(100 * 20000);
        errors++;
        conclude();
    end

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        stall = 1'b0;
        rand_on = 1'b0;
        lfsr_r = 16'h7DE5;
        errors = 0;
        comparisons = 0;
        do_reset();
        run_set();
        drain();
        rand_on <= 1'b1;
        run_set();
        run_set();
        drain();
        rand_on <= 1'b0;
        do_reset();
        conclude();
    end
endmodule
